// ---- psp_consts.vh ----
// constants shared by the pressure sensor serial port and its result buffer
`ifndef PSP_CONSTS_VH
`define PSP_CONSTS_VH

// frame geometry, counted in serial clock periods
`define PSP_START_BITS    5'h03
`define PSP_SETUP_BITS    5'h04
`define PSP_STOP_BITS     5'h03
`define PSP_ACK_CLOCKS    5'h02
`define PSP_WORD_BITS     5'h10
`define PSP_READ_CLOCKS   5'h11
`define PSP_RESET_BITS    21

// recovery pattern, oldest bit in the msb
`define PSP_RESET_PATTERN 21'h1AAAA0

// setup codes, received msb first
`define PSP_SETUP_PRESS   4'hA
`define PSP_SETUP_TEMP    4'h9
`define PSP_SETUP_CAL1    4'h5
`define PSP_SETUP_CAL2    4'h6
`define PSP_SETUP_CAL3    4'h3
`define PSP_SETUP_CAL4    4'hC

// conversion timing against the converter master clock
`define PSP_CONV_TIME_US  35000
`define PSP_CONV_CLK_HZ   32768
`define PSP_TICK_BITS     12

// result buffer shape
`define PSP_FIFO_WIDTH    16
`define PSP_FIFO_DEPTH    32
`define PSP_FIFO_AW       5

`endif

// ---- psp_fifo.v ----
// result buffer between the converter front end and the serial port
`timescale 1ns/100ps
`default_nettype none

module psp_fifo #(
	parameter WIDTH = 16,
	parameter DEPTH = 32,
	parameter AW    = 5
) (
	input  wire             mclk_i,      // system clock
	input  wire             srst_i,      // synchronous reset, high
	input  wire             in_valid_i,  // source offers a word
	input  wire [WIDTH-1:0] in_data_i,   // offered word
	output reg              in_ready_o,  // room for a word
	output wire             out_valid_o, // a word is waiting
	output wire [WIDTH-1:0] out_data_o,  // oldest word
	input  wire             out_ready_i  // sink takes the oldest word
);

	reg [WIDTH-1:0] mem [0:DEPTH-1]; // storage, indexed by pointer
	reg [AW-1:0]    wr_ptr;          // next slot to fill
	reg [AW-1:0]    rd_ptr;          // oldest slot
	reg [AW:0]      count;           // words held

	// depth held as an integer so the cuts below are explicit selects
	localparam integer DEPTH_I    = DEPTH;     // buffer depth
	localparam integer DEPTH_M1   = DEPTH - 1; // index of the last slot
	localparam [AW:0]  FULL_COUNT = DEPTH_I[AW:0];
	localparam [AW-1:0] LAST_SLOT = DEPTH_M1[AW-1:0];

	wire do_wr = in_valid_i & in_ready_o;  // accepted push
	wire do_rd = out_valid_o & out_ready_i; // accepted pop
	wire [AW:0] next_count = count + {{AW{1'b0}}, do_wr} - {{AW{1'b0}}, do_rd};

	assign out_valid_o = (count != {(AW+1){1'b0}});
	assign out_data_o  = mem[rd_ptr];

	// pointers wrap explicitly so a depth that is not a power of two still works
	always @(posedge mclk_i) begin
		if (srst_i) begin
			wr_ptr     <= {AW{1'b0}};
			rd_ptr     <= {AW{1'b0}};
			count      <= {(AW+1){1'b0}};
			in_ready_o <= 1'b0;
		end else begin
			if (do_wr) begin
				mem[wr_ptr] <= in_data_i;
				wr_ptr      <= (wr_ptr == LAST_SLOT) ? {AW{1'b0}} : wr_ptr + 1'b1;
			end
			if (do_rd) begin
				rd_ptr <= (rd_ptr == LAST_SLOT) ? {AW{1'b0}} : rd_ptr + 1'b1;
			end
			count      <= next_count;
			// registered ready: full is known one cycle ahead, no comb path out
			in_ready_o <= (next_count != FULL_COUNT);
		end
	end

endmodule // psp_fifo

`default_nettype wire

// ---- psp_top.v ----
// three-wire command and readout port of a pressure and temperature sensor
`timescale 1ns/100ps
`default_nettype none
`include "psp_consts.vh"

module psp_top #(
	parameter [15:0] CALIB_WORD_ONE   = 16'h1111,               // arbitrary factory value
	parameter [15:0] CALIB_WORD_TWO   = 16'h2222,               // arbitrary factory value
	parameter [15:0] CALIB_WORD_THREE = 16'h3333,               // arbitrary factory value
	parameter [15:0] CALIB_WORD_FOUR  = 16'h4444,               // arbitrary factory value
	parameter integer CONV_TIME_US    = `PSP_CONV_TIME_US,      // conversion time, microseconds
	parameter integer CONV_CLK_HZ     = `PSP_CONV_CLK_HZ,       // converter clock rate
	parameter integer FIFO_WIDTH      = `PSP_FIFO_WIDTH,        // result word width
	parameter integer FIFO_DEPTH      = `PSP_FIFO_DEPTH,        // result buffer depth
	parameter integer FIFO_AW         = `PSP_FIFO_AW            // buffer pointer width
) (
	input  wire                  mclk_i,          // system clock, 50 MHz
	input  wire                  srst_i,          // synchronous reset, high
	input  wire                  sclk_i,          // serial clock pin from host
	input  wire                  din_i,           // serial command pin from host
	input  wire                  conv_clk_i,      // converter master clock pin
	output reg                   dout_o,          // serial data / status pin
	output reg                   conv_start_o,    // pulse: front end starts a conversion
	output reg                   conv_temp_o,     // channel of last start, 1 = temperature
	input  wire                  sample_valid_i,  // front end offers a result
	input  wire [FIFO_WIDTH-1:0] sample_data_i,   // offered result, unsigned
	output wire                  sample_ready_o   // buffer can take a result
);

	// protocol states
	localparam [2:0] ST_IDLE  = 3'h0; // hunting for the start frame
	localparam [2:0] ST_SETUP = 3'h1; // collecting the setup code
	localparam [2:0] ST_STOP  = 3'h2; // checking the stop frame
	localparam [2:0] ST_ACK   = 3'h3; // output high, counting trailing clocks
	localparam [2:0] ST_CONV  = 3'h4; // converter busy, serial clock idle
	localparam [2:0] ST_READ  = 3'h5; // shifting a word out

	// conversion length in converter clock ticks, a longest time so rounded down
	localparam integer CONV_TICKS = (CONV_TIME_US * CONV_CLK_HZ) / 1000000;
	localparam [`PSP_TICK_BITS-1:0] CONV_TICKS_W = CONV_TICKS[`PSP_TICK_BITS-1:0];

	// synchronisers: the first stage is read only by the second
	reg sclk_meta;  // serial clock, first stage
	reg sclk_sync;  // serial clock, second stage
	reg sclk_prev;  // serial clock, delayed for edge find
	reg din_meta;   // command input, first stage
	reg din_sync;   // command input, second stage
	reg cclk_meta;  // converter clock, first stage
	reg cclk_sync;  // converter clock, second stage
	reg cclk_prev;  // converter clock, delayed for edge find

	// protocol state
	reg [2:0]                 state;     // current protocol state
	reg [4:0]                 bit_cnt;   // bits or clocks seen in this phase
	reg [3:0]                 setup;     // setup code being assembled
	reg [`PSP_RESET_BITS-1:0] history;   // last command bits for reset match
	reg [15:0]                word_sh;   // word being shifted out
	reg [`PSP_TICK_BITS-1:0]  tick_cnt;  // converter ticks since start

	// buffer drain side
	wire                  res_valid;  // a result is waiting
	wire [FIFO_WIDTH-1:0] res_data;   // oldest result
	reg                   res_pop;    // take the oldest result

	// edge events on the system clock
	wire sclk_rise = sclk_sync & ~sclk_prev;  // one cycle per serial clock rise
	wire cclk_rise = cclk_sync & ~cclk_prev;  // one cycle per converter tick

	// command history including the bit arriving now
	wire [`PSP_RESET_BITS-1:0] next_history = {history[`PSP_RESET_BITS-2:0], din_sync};
	wire reset_seen = (next_history == `PSP_RESET_PATTERN);

	// conversion is over once the time has run and a result is at hand
	wire conv_done = (tick_cnt >= CONV_TICKS_W) & res_valid;

	// setup code with the bit arriving now, msb first
	wire [3:0] next_setup = {setup[2:0], din_sync};

	// calibration word chosen by a setup code, zero for anything else
	function [15:0] calib_sel;
		input [3:0] code;
		begin
			case (code)
				`PSP_SETUP_CAL1: calib_sel = CALIB_WORD_ONE;
				`PSP_SETUP_CAL2: calib_sel = CALIB_WORD_TWO;
				`PSP_SETUP_CAL3: calib_sel = CALIB_WORD_THREE;
				`PSP_SETUP_CAL4: calib_sel = CALIB_WORD_FOUR;
				default:         calib_sel = 16'h0000;
			endcase
		end
	endfunction

	// true for the four calibration codes
	function is_calib;
		input [3:0] code;
		begin
			is_calib = (code == `PSP_SETUP_CAL1) | (code == `PSP_SETUP_CAL2) |
			           (code == `PSP_SETUP_CAL3) | (code == `PSP_SETUP_CAL4);
		end
	endfunction

	// bring the three pins into the system clock domain
	// the serial clock is only ever an input here, the host owns it
	always @(posedge mclk_i) begin
		if (srst_i) begin
			sclk_meta <= 1'b0;
			sclk_sync <= 1'b0;
			sclk_prev <= 1'b0;
			din_meta  <= 1'b0;
			din_sync  <= 1'b0;
			cclk_meta <= 1'b0;
			cclk_sync <= 1'b0;
			cclk_prev <= 1'b0;
		end else begin
			sclk_meta <= sclk_i;
			sclk_sync <= sclk_meta;
			sclk_prev <= sclk_sync;
			// command and clock share the same two-stage delay, so the bit
			// the host set on the falling edge is stable at the rise
			din_meta  <= din_i;
			din_sync  <= din_meta;
			cclk_meta <= conv_clk_i;
			cclk_sync <= cclk_meta;
			cclk_prev <= cclk_sync;
		end
	end

	// converter tick counter, runs only while a conversion is pending
	// the count saturates so a late front end result cannot wrap it
	always @(posedge mclk_i) begin
		if (srst_i) begin
			tick_cnt <= {`PSP_TICK_BITS{1'b0}};
		end else if (state != ST_CONV) begin
			tick_cnt <= {`PSP_TICK_BITS{1'b0}};
		end else if (cclk_rise && (tick_cnt < CONV_TICKS_W)) begin
			tick_cnt <= tick_cnt + 1'b1;
		end
	end

	// command history, shifted on every serial clock rise in every state
	always @(posedge mclk_i) begin
		if (srst_i) begin
			history <= {`PSP_RESET_BITS{1'b0}};
		end else if (sclk_rise) begin
			history <= next_history;
		end
	end

	// protocol engine
	// everything the host sees moves on a serial clock rise, except the
	// end-of-conversion fall, which happens while the host holds the clock low
	always @(posedge mclk_i) begin
		if (srst_i) begin
			state        <= ST_IDLE;
			bit_cnt      <= 5'h00;
			setup        <= 4'h0;
			word_sh      <= 16'h0000;
			dout_o       <= 1'b0;
			conv_start_o <= 1'b0;
			conv_temp_o  <= 1'b0;
			res_pop      <= 1'b0;
		end else begin
			conv_start_o <= 1'b0;
			res_pop      <= 1'b0;
			if (sclk_rise && reset_seen) begin
				// recovery: the pattern wins over whatever phase we were in
				state   <= ST_IDLE;
				bit_cnt <= 5'h00;
				dout_o  <= 1'b0;
			end else if (sclk_rise) begin
				case (state)
					ST_IDLE: begin
						dout_o <= 1'b0;
						// count consecutive ones; any zero restarts the hunt
						if (din_sync) begin
							if (bit_cnt == `PSP_START_BITS - 5'h01) begin
								state   <= ST_SETUP;
								bit_cnt <= 5'h00;
							end else begin
								bit_cnt <= bit_cnt + 5'h01;
							end
						end else begin
							bit_cnt <= 5'h00;
						end
					end
					ST_SETUP: begin
						// four bits, msb first
						setup <= next_setup;
						if (bit_cnt == `PSP_SETUP_BITS - 5'h01) begin
							state   <= ST_STOP;
							bit_cnt <= 5'h00;
						end else begin
							bit_cnt <= bit_cnt + 5'h01;
						end
					end
					ST_STOP: begin
						if (din_sync) begin
							// a high stop bit means we are out of step: hunt again
							state   <= ST_IDLE;
							bit_cnt <= 5'h00;
						end else if (bit_cnt != `PSP_STOP_BITS - 5'h01) begin
							bit_cnt <= bit_cnt + 5'h01;
						end else begin
							bit_cnt <= 5'h00;
							// last stop bit: act on the code
							if (setup == `PSP_SETUP_PRESS || setup == `PSP_SETUP_TEMP) begin
								state        <= ST_ACK;
								dout_o       <= 1'b1;
								conv_start_o <= 1'b1;
								conv_temp_o  <= (setup == `PSP_SETUP_TEMP);
							end else if (is_calib(setup)) begin
								// the chosen word leaves on the next clocks
								state   <= ST_READ;
								word_sh <= calib_sel(setup);
							end else begin
								// unknown code: nothing to do, stay quiet
								state <= ST_IDLE;
							end
						end
					end
					ST_ACK: begin
						// the host gives two more clocks, then parks the clock
						if (bit_cnt == `PSP_ACK_CLOCKS - 5'h01) begin
							state   <= ST_CONV;
							bit_cnt <= 5'h00;
						end else begin
							bit_cnt <= bit_cnt + 5'h01;
						end
					end
					ST_CONV: begin
						// the host should not clock here; stray clocks are ignored
						// so the status output keeps its meaning
						bit_cnt <= 5'h00;
					end
					ST_READ: begin
						// sixteen data clocks, msb first, then one closing clock
						// a paused clock simply delays the next edge
						if (bit_cnt < `PSP_WORD_BITS) begin
							dout_o  <= word_sh[15];
							word_sh <= {word_sh[14:0], 1'b0};
							bit_cnt <= bit_cnt + 5'h01;
						end else begin
							// seventeenth clock: line back low, ready for next frame
							dout_o  <= 1'b0;
							state   <= ST_IDLE;
							bit_cnt <= 5'h00;
						end
					end
					default: begin
						state   <= ST_IDLE;
						bit_cnt <= 5'h00;
						dout_o  <= 1'b0;
					end
				endcase
			end else if (state == ST_CONV && conv_done && !res_pop) begin
				// end of conversion: take the result and drop the line
				// the falling edge is the host's cue to read
				res_pop <= 1'b1;
				word_sh <= res_data[15:0];
				dout_o  <= 1'b0;
				state   <= ST_READ;
				bit_cnt <= 5'h00;
			end
		end
	end

	// result buffer; its ready goes back to the front end, so results back up
	// there when the host is slow to start conversions
	psp_fifo #(
		.WIDTH (FIFO_WIDTH),
		.DEPTH (FIFO_DEPTH),
		.AW    (FIFO_AW)
	) psp_fifo_i (
		.mclk_i      (mclk_i),
		.srst_i      (srst_i),
		.in_valid_i  (sample_valid_i),
		.in_data_i   (sample_data_i),
		.in_ready_o  (sample_ready_o),
		.out_valid_o (res_valid),
		.out_data_o  (res_data),
		.out_ready_i (res_pop)
	);

endmodule // psp_top

`default_nettype wire

// ---- psp_host.sv ----
// host model: makes the serial clock and commands, reads data out
`timescale 1ns/100ps
`default_nettype none
`include "psp_consts.vh"
module psp_host (
	input  wire logic mclk_i, // pacing clock
	input  wire logic dout_i, // device data and status
	output var  logic sclk_o, // serial clock, made only here
	output var  logic din_o   // command bit
);
	// serial clock idles low outside frames
	initial begin
		sclk_o = 1'b0;
		din_o = 1'b0;
	end
	// one 160 ns clock, low 60 high 100 so dout has settled before the fall
	task automatic clk_bit(input logic b, output logic s);
		din_o = b;
		repeat (3) @(negedge mclk_i);
		sclk_o = 1'b1;
		repeat (5) @(negedge mclk_i);
		s = dout_i;
		sclk_o = 1'b0;
	endtask
	// msb first; s holds dout of the last clock
	task automatic send(input logic [20:0] v, input int n, output logic s);
		for (int i = n - 1; i >= 0; i--)
			clk_bit(v[i], s);
	endtask
	// exactly three ones, or extra ones would slip into the setup code
	task automatic frame(input logic [3:0] c, output logic s);
		send({11'h000, 3'h7, c, 3'h0}, 10, s);
	endtask
	// dout is ignored while the pattern shifts in
	task automatic reset_seq;
		logic s;
		send(`PSP_RESET_PATTERN, `PSP_RESET_BITS, s);
	endtask
	// sixteen data clocks and the closing one, optional hold mid-word
	task automatic read16(input int hold, output logic [15:0] w);
		logic s;
		for (int i = 15; i >= 0; i--) begin
			clk_bit(1'b0, s);
			w[i] = s;
			if (i == 8) repeat (hold) @(negedge mclk_i);
		end
		clk_bit(1'b0, s);
	endtask
endmodule // psp_host
`default_nettype wire

// ---- psp_top_sva.sv ----
// concurrent checks on the pins of the sensor serial port
`timescale 1ns/100ps
`default_nettype none
module psp_top_sva (
	input wire logic mclk_i,        // system clock
	input wire logic srst_i,        // synchronous reset
	input wire logic sclk_i,        // host serial clock
	input wire logic dout_o,        // data and status pin
	input wire logic conv_start_o,  // start pulse
	input wire logic conv_temp_o,   // channel of last start
	input wire logic sample_ready_o // buffer room
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (srst_i);
	// ack edge lands while the serial clock is still high
	sequence s_ack;
		$rose(dout_o) ##0 sclk_i;
	endsequence
	// busy level holds for at least eight system clocks from the start pulse
	sequence s_busy;
		dout_o [*8];
	endsequence
	a_start_acked: assert property (conv_start_o |-> s_ack)
		else $error("start without ack edge");
	a_busy_holds: assert property (conv_start_o |-> s_busy)
		else $error("busy level dropped early");
	a_start_pulse: assert property (conv_start_o |=> !conv_start_o)
		else $error("start longer than one cycle");
	a_start_on_rise: assert property (conv_start_o |-> sclk_i)
		else $error("start outside a clock rise");
	a_rise_on_clk: assert property ($rose(dout_o) |-> sclk_i)
		else $error("dout rose with serial clock low");
	a_dout_stands: assert property ($changed(dout_o) |=> $stable(dout_o) [*2])
		else $error("dout changed twice in a row");
	a_temp_on_start: assert property ($changed(conv_temp_o) |-> conv_start_o)
		else $error("channel changed without start");
	a_ready_after_rst: assert property ($fell(srst_i) |=> sample_ready_o)
		else $error("buffer not ready after reset");
endmodule // psp_top_sva
bind psp_top psp_top_sva psp_top_sva_i (.mclk_i(mclk_i), .srst_i(srst_i), .sclk_i(sclk_i),
	.dout_o(dout_o), .conv_start_o(conv_start_o), .conv_temp_o(conv_temp_o),
	.sample_ready_o(sample_ready_o));
`default_nettype wire

// ---- tb_psp_top.sv ----
// self-checking bench for the sensor serial port
`timescale 1ns/100ps
`default_nettype none
`include "psp_consts.vh"
module tb_psp_top;
	logic        mclk = 1'b0;      // system clock
	logic        srst = 1'b1;      // reset
	logic        cclk = 1'b0;      // converter clock
	logic        sv   = 1'b0;      // front end offers a word
	logic [15:0] sd   = 16'h0000;  // offered word
	wire         sclk, din, dout, cstart, ctemp, srdy;
	int          failures = 0;
	int          total_checks = 0;
	int          starts = 0;       // conversion start pulses seen
	logic [3:0]  cc [4] = '{`PSP_SETUP_CAL1, `PSP_SETUP_CAL2, `PSP_SETUP_CAL3, `PSP_SETUP_CAL4};
	logic [15:0] cw [4] = '{16'hC3A5, 16'h5A0F, 16'h0001, 16'hFFFE};
	initial forever #10 mclk = ~mclk;
	// converter clock sped up to 1 MHz so a conversion is 3 us, not ms
	initial forever #500 cclk = ~cclk;
	// the start pulse lasts one cycle, so each falling edge sees it once
	always @(negedge mclk) if (cstart === 1'b1) starts++;
	psp_top #(.CALIB_WORD_ONE(16'hC3A5), .CALIB_WORD_TWO(16'h5A0F), .CALIB_WORD_THREE(16'h0001),
		.CALIB_WORD_FOUR(16'hFFFE), .CONV_TIME_US(100)) psp_top_i (.mclk_i(mclk), .srst_i(srst),
		.sclk_i(sclk), .din_i(din), .conv_clk_i(cclk), .dout_o(dout), .conv_start_o(cstart),
		.conv_temp_o(ctemp), .sample_valid_i(sv), .sample_data_i(sd), .sample_ready_o(srdy));
	psp_host psp_host_i (.mclk_i(mclk), .dout_i(dout), .sclk_o(sclk), .din_o(din));
	// compare and count, report a mismatch at once
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic results;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// recovery first, then the four words; no ack for these
	task automatic t_cal;
		logic s;
		logic [15:0] w;
		psp_host_i.reset_seq();
		for (int k = 0; k < 4; k++) begin
			psp_host_i.frame(cc[k], s);
			chk(s, 1'b0);
			psp_host_i.read16(0, w);
			chk(w, cw[k]);
			chk(dout, 1'b0);
		end
	endtask
	// a high stop bit or an unknown code returns to the hunt with the line low
	task automatic t_bad;
		logic s;
		logic [15:0] w;
		psp_host_i.send({11'h000, 3'h7, `PSP_SETUP_CAL1, 3'h4}, 10, s);
		psp_host_i.read16(0, w);
		chk(w, 16'h0000);
		psp_host_i.frame(4'h0, s);
		psp_host_i.read16(0, w);
		chk(w, 16'h0000);
		chk(dout, 1'b0);
	endtask
	// fill the buffer until it refuses; nothing drains it yet
	task automatic t_fill;
		int n = 0;
		repeat (40) begin
			@(negedge mclk);
			sv = 1'b1;
			sd = 16'hFFFF - 16'(n);
			if (srdy) n++;
		end
		@(negedge mclk);
		sv = 1'b0;
		chk(16'(n), 16'(`PSP_FIFO_DEPTH));
	endtask
	// serial clock stays low until dout falls, bounded
	task automatic wait_low;
		int t = 0;
		while (dout !== 1'b0 && t < 5000) begin
			@(negedge mclk);
			t++;
		end
		chk(dout, 1'b0);
	endtask
	// 32 conversions drain the buffer oldest first, channels alternate
	task automatic t_conv;
		logic s;
		logic [15:0] w;
		for (int i = 0; i < 32; i++) begin
			psp_host_i.frame(i[0] ? `PSP_SETUP_TEMP : `PSP_SETUP_PRESS, s);
			chk(s, 1'b1);
			chk(ctemp, i[0]);
			chk(16'(starts), 16'(i + 1));
			psp_host_i.clk_bit(1'b0, s);
			psp_host_i.clk_bit(1'b0, s);
			chk(s, 1'b1);
			wait_low();
			psp_host_i.read16(i == 5 ? 300 : 0, w);
			chk(w, 16'hFFFF - 16'(i));
			chk(dout, 1'b0);
		end
	endtask
	// empty buffer keeps the conversion busy; only the pattern frees it
	task automatic t_rst;
		logic s;
		logic [15:0] w;
		psp_host_i.frame(`PSP_SETUP_PRESS, s);
		chk(16'(starts), 16'h0021);
		chk(ctemp, 1'b0);
		psp_host_i.clk_bit(1'b0, s);
		psp_host_i.clk_bit(1'b0, s);
		repeat (400) @(negedge mclk);
		chk(dout, 1'b1);
		psp_host_i.reset_seq();
		chk(dout, 1'b0);
		psp_host_i.frame(`PSP_SETUP_CAL2, s);
		psp_host_i.read16(0, w);
		chk(w, cw[1]);
	endtask
	// system reset in the middle of a word read drops the line and restarts cleanly
	task automatic t_srst;
		logic s;
		logic [15:0] w;
		psp_host_i.frame(cc[3], s);
		repeat (4) psp_host_i.clk_bit(1'b0, s);
		chk(s, 1'b1);
		srst = 1'b1;
		repeat (4) @(negedge mclk);
		srst = 1'b0;
		repeat (4) @(negedge mclk);
		chk(dout, 1'b0);
		chk(srdy, 1'b1);
		psp_host_i.frame(cc[2], s);
		psp_host_i.read16(0, w);
		chk(w, cw[2]);
		chk(dout, 1'b0);
	endtask
	initial begin
		repeat (12) @(negedge mclk);
		srst = 1'b0;
		repeat (4) @(negedge mclk);
		t_cal();
		t_bad();
		t_fill();
		t_conv();
		t_rst();
		t_srst();
		results();
	end
	// watchdog: traffic needs about 300 us
	initial begin
		#1_000_000;
		failures++;
		results();
	end
endmodule // tb_psp_top
`default_nettype wire
